// ### logic/aitp_pkg.sv
package aitp_pkg;
	localparam logic [6:0] ADDR_SEL_HI = 7'h1D;
	localparam logic [6:0] ADDR_SEL_LO = 7'h53;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [3:0] BIT_NONE = 4'h0;
	localparam logic RW_READ = 1'b1;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_ACKIN} aitp_state_t;
endpackage

// ### logic/aitp_bridge.sv
`timescale 1ns/100ps
// system-clock side of the register access handshake
module aitp_bridge (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic req_tog,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_data,
	input wire logic req_we,
	output logic ack_tog,
	output logic [7:0] ack_data,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_d;
		logic pend;
		logic ack_tog;
		logic [7:0] ack_data;
		logic reg_wr;
		logic reg_rd;
		logic [7:0] reg_addr;
		logic [7:0] reg_wdata;
	} aitp_bridge_t;

	aitp_bridge_t st;
	aitp_bridge_t next_st;
	logic req_edge;

	assign req_edge = st.req_s2 != st.req_d;

	always_comb
	begin
		next_st = st;
		next_st.req_s1 = req_tog;
		next_st.req_s2 = st.req_s1;
		next_st.req_d = st.req_s2;
		next_st.reg_wr = 1'b0;
		next_st.reg_rd = 1'b0;
		next_st.pend = 1'b0;
		// link fields are held stable until the answer toggle returns
		if (req_edge)
		begin
			next_st.reg_addr = req_addr;
			next_st.reg_wdata = req_data;
			next_st.reg_wr = req_we;
			next_st.reg_rd = !req_we;
			next_st.pend = 1'b1;
		end
		if (st.pend)
		begin
			if (st.reg_rd)
				next_st.ack_data = reg_rdata;
			next_st.ack_tog = !st.ack_tog;
		end
		if (rst)
		begin
			next_st = '0;
			next_st.ack_data = aitp_pkg::DATA_RESET;
			next_st.reg_addr = aitp_pkg::PTR_RESET;
			next_st.reg_wdata = aitp_pkg::DATA_RESET;
		end
	end

	always_ff @(posedge clk_sys)
		st <= next_st;

	assign ack_tog = st.ack_tog;
	assign ack_data = st.ack_data;
	assign reg_wr = st.reg_wr;
	assign reg_rd = st.reg_rd;
	assign reg_addr = st.reg_addr;
	assign reg_wdata = st.reg_wdata;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_req_seen;
		req_edge;
	endsequence
	sequence s_strobe_then_answer;
		(reg_wr ^ reg_rd) ##1 $changed(ack_tog);
	endsequence

	a_access_answer: assert property (s_req_seen |=> s_strobe_then_answer)
		else $error("register access not answered in two cycles");
	a_strobe_cause: assert property ((reg_wr || reg_rd) |-> $past(req_edge))
		else $error("register strobe without a request");
endmodule

// ### logic/aitp_target.sv
`timescale 1ns/100ps
// Summary of operation
// - Act as a two-wire target only while chip select is high.
// - Follow 100 kHz and 400 kHz bus clocks by oversampling.
// - Support single and multi-byte register reads and writes.
// - Select pin high: answer address 0x1D, bytes 0x3A write, 0x3B read.
// - Select pin low: answer address 0x53, bytes 0xA6 write, 0xA7 read.
// - Read may follow the address write by repeated start or stop-start.
// - Traffic while chip select is low is ignored; system gates data.
module aitp_target (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_link,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic chip_select,
	input wire logic target_address_select_pin,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic cs_s1;
		logic cs_s2;
		logic sel_s1;
		logic sel_s2;
		logic rst_s1;
		logic rst_s2;
		logic ack_s1;
		logic ack_s2;
		logic ack_d;
		aitp_pkg::aitp_state_t state;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic rw;
		logic first;
		logic [7:0] ptr;
		logic [7:0] rbuf;
		logic req_tog;
		logic [7:0] req_addr;
		logic [7:0] req_data;
		logic req_we;
		logic sda_oe;
		logic sda_o;
	} aitp_link_t;

	aitp_link_t st;
	aitp_link_t next_st;
	logic ack_tog;
	logic [7:0] ack_data;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic busy;
	logic byte_done;
	logic [6:0] own_addr;

	// bus pins are sampled on the link clock; the oversampling follows both bus speeds
	assign scl_rise = st.scl_s2 && !st.scl_d;
	assign scl_fall = !st.scl_s2 && st.scl_d;
	assign start_c = st.scl_s2 && st.scl_d && !st.sda_s2 && st.sda_d;
	assign stop_c = st.scl_s2 && st.scl_d && st.sda_s2 && !st.sda_d;
	assign busy = st.req_tog != st.ack_s2;
	assign byte_done = scl_fall && st.bitcnt == aitp_pkg::BITS_PER_BYTE;
	assign own_addr = st.sel_s2 ? aitp_pkg::ADDR_SEL_HI : aitp_pkg::ADDR_SEL_LO;

	always_comb
	begin
		next_st = st;
		next_st.scl_s1 = scl_in;
		next_st.scl_s2 = st.scl_s1;
		next_st.scl_d = st.scl_s2;
		next_st.sda_s1 = sda_in;
		next_st.sda_s2 = st.sda_s1;
		next_st.sda_d = st.sda_s2;
		next_st.cs_s1 = chip_select;
		next_st.cs_s2 = st.cs_s1;
		next_st.sel_s1 = target_address_select_pin;
		next_st.sel_s2 = st.sel_s1;
		next_st.rst_s1 = rst;
		next_st.rst_s2 = st.rst_s1;
		next_st.ack_s1 = ack_tog;
		next_st.ack_s2 = st.ack_s1;
		next_st.ack_d = st.ack_s2;
		next_st.sda_o = 1'b0;
		// answer word is stable once its toggle has crossed
		if (st.ack_s2 != st.ack_d)
			next_st.rbuf = ack_data;
		if (!st.cs_s2)
		begin
			next_st.state = aitp_pkg::ST_IDLE;
			next_st.sda_oe = 1'b0;
		end
		else if (start_c)
		begin
			next_st.state = aitp_pkg::ST_ADDR;
			next_st.bitcnt = aitp_pkg::BIT_NONE;
			next_st.sda_oe = 1'b0;
		end
		else if (stop_c)
		begin
			next_st.state = aitp_pkg::ST_IDLE;
			next_st.sda_oe = 1'b0;
		end
		else
		begin
			case (st.state)
				aitp_pkg::ST_ADDR, aitp_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						next_st.shift = {st.shift[6:0], st.sda_s2};
						next_st.bitcnt = st.bitcnt + 4'h1;
					end
					else if (byte_done)
					begin
						next_st.bitcnt = aitp_pkg::BIT_NONE;
						if (st.state == aitp_pkg::ST_RX)
						begin
							next_st.sda_oe = 1'b1;
							next_st.state = aitp_pkg::ST_ACK;
							next_st.first = 1'b0;
							if (st.first)
								next_st.ptr = st.shift;
							else if (!busy)
							begin
								next_st.req_tog = !st.req_tog;
								next_st.req_addr = st.ptr;
								next_st.req_data = st.shift;
								next_st.req_we = 1'b1;
								next_st.ptr = st.ptr + 8'h01;
							end
						end
						else if (st.shift[7:1] == own_addr)
						begin
							next_st.sda_oe = 1'b1;
							next_st.state = aitp_pkg::ST_ACK;
							next_st.rw = st.shift[0];
							next_st.first = st.shift[0] != aitp_pkg::RW_READ;
							if (st.shift[0] == aitp_pkg::RW_READ && !busy)
							begin
								next_st.req_tog = !st.req_tog;
								next_st.req_addr = st.ptr;
								next_st.req_we = 1'b0;
								next_st.ptr = st.ptr + 8'h01;
							end
						end
						else
							next_st.state = aitp_pkg::ST_IDLE;
					end
				end
				aitp_pkg::ST_ACK, aitp_pkg::ST_ACKIN:
				begin
					if (st.state == aitp_pkg::ST_ACKIN && scl_rise && st.sda_s2)
						next_st.state = aitp_pkg::ST_IDLE;
					else if (scl_fall && st.rw == aitp_pkg::RW_READ)
					begin
						next_st.state = aitp_pkg::ST_TX;
						next_st.sda_oe = !st.rbuf[7];
						next_st.shift = {st.rbuf[6:0], 1'b0};
						next_st.bitcnt = aitp_pkg::BIT_FIRST;
					end
					else if (scl_fall)
					begin
						next_st.state = aitp_pkg::ST_RX;
						next_st.sda_oe = 1'b0;
					end
				end
				aitp_pkg::ST_TX:
				begin
					if (byte_done)
					begin
						next_st.sda_oe = 1'b0;
						next_st.state = aitp_pkg::ST_ACKIN;
						next_st.bitcnt = aitp_pkg::BIT_NONE;
						if (!busy)
						begin
							next_st.req_tog = !st.req_tog;
							next_st.req_addr = st.ptr;
							next_st.req_we = 1'b0;
							next_st.ptr = st.ptr + 8'h01;
						end
					end
					else if (scl_fall)
					begin
						next_st.sda_oe = !st.shift[7];
						next_st.shift = {st.shift[6:0], 1'b0};
						next_st.bitcnt = st.bitcnt + 4'h1;
					end
				end
				default:
					next_st.state = aitp_pkg::ST_IDLE;
			endcase
		end
		if (st.rst_s2)
		begin
			next_st.state = aitp_pkg::ST_IDLE;
			next_st.bitcnt = aitp_pkg::BIT_NONE;
			next_st.shift = aitp_pkg::DATA_RESET;
			next_st.rw = 1'b0;
			next_st.first = 1'b0;
			next_st.ptr = aitp_pkg::PTR_RESET;
			next_st.rbuf = aitp_pkg::DATA_RESET;
			next_st.req_tog = 1'b0;
			next_st.req_addr = aitp_pkg::PTR_RESET;
			next_st.req_data = aitp_pkg::DATA_RESET;
			next_st.req_we = 1'b0;
			next_st.sda_oe = 1'b0;
			next_st.ack_s1 = 1'b0;
			next_st.ack_s2 = 1'b0;
			next_st.ack_d = 1'b0;
		end
	end

	always_ff @(posedge clk_link)
		st <= next_st;

	aitp_bridge u_bridge (
		.clk_sys(clk_sys),
		.rst(rst),
		.req_tog(st.req_tog),
		.req_addr(st.req_addr),
		.req_data(st.req_data),
		.req_we(st.req_we),
		.ack_tog(ack_tog),
		.ack_data(ack_data),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);

	assign sda_out = st.sda_o;
	assign sda_oe = st.sda_oe;

	default clocking lb @(posedge clk_link); endclocking
	default disable iff (st.rst_s2);

	sequence s_addr_end(logic [6:0] a, logic s);
		st.state == aitp_pkg::ST_ADDR && byte_done && st.cs_s2 && !start_c && !stop_c
			&& st.shift[7:1] == a && st.sel_s2 == s;
	endsequence

	a_addr_ack_hi: assert property (s_addr_end(aitp_pkg::ADDR_SEL_HI, 1'b1)
		|=> sda_oe && st.state == aitp_pkg::ST_ACK)
		else $error("address 0x1D not acknowledged with select high");
	a_addr_ack_lo: assert property (s_addr_end(aitp_pkg::ADDR_SEL_LO, 1'b0)
		|=> sda_oe && st.state == aitp_pkg::ST_ACK)
		else $error("address 0x53 not acknowledged with select low");
	a_foreign_quiet: assert property (st.state == aitp_pkg::ST_ADDR && byte_done && st.cs_s2
		&& !start_c && !stop_c && st.shift[7:1] != own_addr |=> !sda_oe ##1 !sda_oe)
		else $error("foreign address acknowledged");
	a_start_restart: assert property (start_c && st.cs_s2
		|=> st.state == aitp_pkg::ST_ADDR && st.bitcnt == 4'h0 && !sda_oe)
		else $error("start not taken as address phase");
	a_cs_low_idle: assert property (!st.cs_s2 |=> st.state == aitp_pkg::ST_IDLE && !sda_oe)
		else $error("bus active while chip select low");
	a_write_ack: assert property (st.state == aitp_pkg::ST_RX && byte_done && st.cs_s2
		&& !start_c && !stop_c |=> sda_oe [*2])
		else $error("written byte not acknowledged");
	a_ptr_advance: assert property (st.state == aitp_pkg::ST_RX && byte_done && st.cs_s2
		&& !start_c && !stop_c && !st.first && !busy |=> st.ptr == $past(st.ptr) + 8'h01)
		else $error("pointer did not advance after data byte");
	a_read_fetch: assert property (st.state == aitp_pkg::ST_TX && byte_done && st.cs_s2
		&& !start_c && !stop_c && !busy |=> $changed(st.req_tog) && !st.req_we && !sda_oe)
		else $error("next read byte not requested after byte");
endmodule

// ### sim/aitp_host_model.sv
`timescale 1ns/100ps
// bus host controller; sda is open drain with a pull-up, scl rests high between frames
module aitp_host_model (
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	int thalf = 1300; // half bit time in ns, within the 400 kHz bus speed
	int sample_output_rate = 200; // configured sample rate in kHz, set by the testbench to 1000000 / thalf
	logic sda_h = 1'b1;
	initial scl = 1'b1;
	assign sda = sda_h & ~sda_oe;
	task automatic bit_x(input logic b, output logic s);
		#(thalf / 2) sda_h = b;
		#(thalf / 2) scl = 1'b1;
		#(thalf) s = sda;
		scl = 1'b0;
	endtask
	task automatic start_cond();
		#(thalf / 2) sda_h = 1'b1;
		#(thalf / 2) scl = 1'b1;
		#(thalf) sda_h = 1'b0;
		#(thalf) scl = 1'b0;
	endtask
	task automatic stop_cond();
		#(thalf / 2) sda_h = 1'b0;
		#(thalf / 2) scl = 1'b1;
		#(thalf) sda_h = 1'b1;
		#(thalf);
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(last, s); // ack to continue, nack on the final byte
	endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic rst = 1'b1;
	logic chip_select = 1'b1; // driven to a definite level
	logic target_address_select_pin = 1'b1;
	logic scl;
	logic sda;
	logic sda_oe;
	logic sda_out;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [15:0] wr_q[$];
	logic [7:0] rd_q[$];
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	always #62.5 clk_link = ~clk_link;
	// register file model: contents derived from the address
	assign reg_rdata = reg_addr ^ 8'h5C;
	aitp_target u_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_link(clk_link),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.chip_select(chip_select),
		.target_address_select_pin(target_address_select_pin),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);
	aitp_host_model u_host (
		.sda_oe(sda_oe),
		.scl(scl),
		.sda(sda)
	);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 98000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	always @(posedge clk_sys)
	begin
		if (reg_wr === 1'b1)
		begin
			if (wr_q.size() == 0)
				chk("unexpected write", 16'hFFFF, 16'h0000);
			else
				chk("register write", wr_q.pop_front(), {reg_addr, reg_wdata});
		end
		if (reg_rd === 1'b1)
		begin
			if (rd_q.size() == 0)
				chk("unexpected read", 16'hFFFF, 16'h0000);
			else
				chk("register read", {8'h00, rd_q.pop_front()}, {8'h00, reg_addr});
		end
		if (sda_oe === 1'b1)
			chk("drive level", 16'h0000, {15'h0000, sda_out});
	end
	task automatic write_frame(input logic [7:0] ab, input logic [7:0] ptr, input int n,
		input logic hit);
		logic ack;
		logic [7:0] d;
		u_host.start_cond();
		u_host.wr_byte(ab, ack);
		chk("address ack", {15'h0000, hit}, {15'h0000, ack});
		if (hit)
		begin
			u_host.wr_byte(ptr, ack);
			for (int i = 0; i < n; i++)
			begin
				d = 8'($urandom);
				wr_q.push_back({ptr + 8'(i), d});
				u_host.wr_byte(d, ack);
				chk("data ack", 16'h0001, {15'h0000, ack});
			end
		end
		u_host.stop_cond();
	endtask
	task automatic read_frame(input logic [7:0] wa, input logic [7:0] ptr, input logic restart,
		input int n);
		logic ack;
		logic [7:0] d;
		// one fetch per byte plus the prefetch behind the last one
		for (int i = 0; i <= n; i++)
			rd_q.push_back(ptr + 8'(i));
		u_host.start_cond();
		u_host.wr_byte(wa, ack);
		u_host.wr_byte(ptr, ack);
		if (!restart)
			u_host.stop_cond(); // stop then start instead of a repeated start
		u_host.start_cond();
		u_host.wr_byte(wa | 8'h01, ack);
		chk("read address ack", 16'h0001, {15'h0000, ack});
		for (int i = 0; i < n; i++)
		begin
			u_host.rd_byte(i == n - 1, d);
			chk("read data", {8'h00, (ptr + 8'(i)) ^ 8'h5C}, {8'h00, d});
		end
		u_host.stop_cond();
	endtask
	initial
	begin
		void'($urandom(32'hC8DF));
		// reset spans several link clock edges as well
		repeat (40) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (60) @(posedge clk_sys);
		for (int k = 0; k < 2; k++)
		begin
			u_host.thalf = k ? 1300 : 5000;
			u_host.sample_output_rate = 1000000 / u_host.thalf;
			write_frame(8'h3A, 8'($urandom) & 8'h3F, k ? 3 : 1, 1'b1);
			$display("write burst done at half bit %0d ns", u_host.thalf);
		end
		read_frame(8'h3A, 8'($urandom) & 8'h3F, 1'b1, 3);
		$display("read with repeated start done");
		write_frame(8'hA6, 8'h00, 0, 1'b0);
		$display("other address ignored done");
		@(posedge clk_sys);
		target_address_select_pin <= 1'b0;
		repeat (100) @(posedge clk_sys);
		write_frame(8'hA6, 8'h40, 1, 1'b1);
		write_frame(8'h3A, 8'h00, 0, 1'b0);
		read_frame(8'hA6, 8'h40, 1'b0, 2);
		$display("alternate address done");
		@(posedge clk_sys);
		chip_select <= 1'b0;
		repeat (100) @(posedge clk_sys);
		write_frame(8'hA6, 8'h00, 0, 1'b0);
		@(posedge clk_sys);
		chip_select <= 1'b1;
		repeat (100) @(posedge clk_sys);
		$display("chip select low done");
		chk("pending writes", 16'h0000, 16'(wr_q.size()));
		chk("pending reads", 16'h0000, 16'(rd_q.size()));
		tally_and_finish();
	end
endmodule
